// >>> uih_consts.svh
`ifndef UIH_CONSTS_SVH
`define UIH_CONSTS_SVH

// ****************************************************************
// Command indexes (read code, write code)
// ****************************************************************
`define UIH_CMD_HWCFG_RD 8'h20
`define UIH_CMD_HWCFG_WR 8'hA0
`define UIH_CMD_G2ST_RD 8'h03
`define UIH_CMD_G2ST_WR 8'h83
`define UIH_CMD_G2EN_RD 8'h04
`define UIH_CMD_G2EN_WR 8'h84
`define UIH_CMD_G1ST_RD 8'h24
`define UIH_CMD_G1ST_WR 8'hA4
`define UIH_CMD_G1EN_RD 8'h25
`define UIH_CMD_G1EN_WR 8'hA5
`define UIH_CMD_SOFT_RESET 8'hA9

// ****************************************************************
// Field positions
// ****************************************************************
`define UIH_HWCFG_PIN_EN_BIT 0
`define UIH_HWCFG_TRIG_BIT 1
`define UIH_HWCFG_POL_BIT 2
`define UIH_G2_MASTER_EN_BIT 31
`define UIH_G1_OPREQ_BIT 4

// ****************************************************************
// Reset values
// ****************************************************************
`define UIH_HWCFG_RESET 16'h0000
`define UIH_G2EN_RESET 32'h0000_0000
`define UIH_G1EN_RESET 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define UIH_CLK_PERIOD_NS 8
`define UIH_EDGE_PULSE_NS 160
`define UIH_EDGE_PULSE_CYC ((`UIH_EDGE_PULSE_NS + `UIH_CLK_PERIOD_NS - 1) / `UIH_CLK_PERIOD_NS)

`endif

// >>> uih_pkg.sv
package uih_pkg;

  typedef enum logic [1:0] {
    UIH_MODE_LEVEL_LOW = 2'b00,
    UIH_MODE_LEVEL_HIGH = 2'b01,
    UIH_MODE_EDGE_LOW = 2'b10,
    UIH_MODE_EDGE_HIGH = 2'b11
  } uih_pin_mode_t;

  typedef enum logic [0:0] {
    UIH_PULSE_IDLE = 1'b0,
    UIH_PULSE_ACTIVE = 1'b1
  } uih_pulse_state_t;

endpackage

// >>> uih_pin_drive.sv
`timescale 1ns/1ps
`include "uih_consts.svh"

module uih_pin_drive #(
  parameter int PULSE_CYC = `UIH_EDGE_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic irq_any_i,
  input wire logic pin_en_i,
  input wire uih_pkg::uih_pin_mode_t mode_i,
  output logic int_o
);

  localparam int CW = $clog2(PULSE_CYC + 1);

  logic latch_r;
  logic latch_q_r;
  logic [CW-1:0] cnt_r;
  uih_pkg::uih_pulse_state_t st_r;
  logic latch_nxt;
  logic rise;
  logic active;
  logic int_nxt;

  // ****************************************************************
  // Latch, transparent only while the pin is enabled
  // ****************************************************************
  assign latch_nxt = pin_en_i ? irq_any_i : latch_r;
  assign rise = latch_r & ~latch_q_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_r <= 1'b0;
      latch_q_r <= 1'b0;
    end else if (soft_rst_i) begin
      latch_r <= 1'b0;
      latch_q_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      latch_q_r <= latch_r;
    end
  end

  // ****************************************************************
  // Fixed length pulse for the edge modes
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= uih_pkg::UIH_PULSE_IDLE;
      cnt_r <= '0;
    end else if (soft_rst_i) begin
      st_r <= uih_pkg::UIH_PULSE_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (st_r)
        uih_pkg::UIH_PULSE_IDLE: begin
          if (rise) begin
            st_r <= uih_pkg::UIH_PULSE_ACTIVE;
            cnt_r <= CW'(PULSE_CYC - 1);
          end
        end
        uih_pkg::UIH_PULSE_ACTIVE: begin
          if (cnt_r == '0) begin
            st_r <= uih_pkg::UIH_PULSE_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Mode and polarity
  // ****************************************************************
  always_comb begin
    active = 1'b0;
    int_nxt = 1'b1;
    unique case (mode_i)
      uih_pkg::UIH_MODE_LEVEL_LOW: begin
        active = latch_r;
        int_nxt = ~active;
      end
      uih_pkg::UIH_MODE_LEVEL_HIGH: begin
        active = latch_r;
        int_nxt = active;
      end
      uih_pkg::UIH_MODE_EDGE_LOW: begin
        active = (st_r == uih_pkg::UIH_PULSE_ACTIVE);
        int_nxt = ~active;
      end
      uih_pkg::UIH_MODE_EDGE_HIGH: begin
        active = (st_r == uih_pkg::UIH_PULSE_ACTIVE);
        int_nxt = active;
      end
    endcase
  end

  assign int_o = int_nxt;

endmodule

// >>> uih_irq_top.sv
`timescale 1ns/1ps
`include "uih_consts.svh"

module uih_irq_top #(
  parameter int G2_EVENTS = 6,
  parameter int G1_EVENTS = 6,
  parameter int PULSE_CYC = `UIH_EDGE_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic a0_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic [G2_EVENTS-1:0] g2_event_i,
  input wire logic [G1_EVENTS-1:0] g1_event_i,
  output logic int_o
);

  logic wr_n_q_r;
  logic rd_n_q_r;
  logic [7:0] cmd_r;
  logic phase_r;
  logic [15:0] hwcfg_r;
  logic [G2_EVENTS-1:0] g2_st_r;
  logic [31:0] g2_en_r;
  logic [G1_EVENTS-1:0] g1_st_r;
  logic [15:0] g1_en_r;
  logic [15:0] data_r;

  // ****************************************************************
  // Bus phase decode
  // ****************************************************************
  logic wr_edge;
  logic rd_end;
  logic wr_cmd;
  logic wr_data;
  logic rd_data;
  logic soft_rst;
  logic lo;
  logic hi;

  assign wr_edge = ~cs_n_i & ~wr_n_i & wr_n_q_r;
  assign rd_end = ~cs_n_i & rd_n_i & ~rd_n_q_r & ~a0_i;
  assign wr_cmd = wr_edge & a0_i & (data_i[15:8] == 8'h00);
  assign wr_data = wr_edge & ~a0_i;
  assign rd_data = ~cs_n_i & ~rd_n_i & ~a0_i;
  assign soft_rst = wr_cmd & (data_i[7:0] == `UIH_CMD_SOFT_RESET);
  assign lo = ~phase_r;
  assign hi = phase_r;

  // ****************************************************************
  // Register write strobes
  // ****************************************************************
  logic hwcfg_we;
  logic g2st_lo_we;
  logic g2en_lo_we;
  logic g2en_hi_we;
  logic g1st_we;
  logic g1en_we;

  assign hwcfg_we = wr_data & lo & (cmd_r == `UIH_CMD_HWCFG_WR);
  assign g2st_lo_we = wr_data & lo & (cmd_r == `UIH_CMD_G2ST_WR);
  assign g2en_lo_we = wr_data & lo & (cmd_r == `UIH_CMD_G2EN_WR);
  assign g2en_hi_we = wr_data & hi & (cmd_r == `UIH_CMD_G2EN_WR);
  assign g1st_we = wr_data & lo & (cmd_r == `UIH_CMD_G1ST_WR);
  assign g1en_we = wr_data & lo & (cmd_r == `UIH_CMD_G1EN_WR);

  // ****************************************************************
  // Interrupt aggregation
  // ****************************************************************
  logic [G2_EVENTS-1:0] g2_clr;
  logic [G1_EVENTS-1:0] g1_clr;
  logic [G1_EVENTS-1:0] g1_set;
  logic g2_any;
  logic op_req;
  logic g1_any;
  logic [G2_EVENTS-1:0] g2_st_nxt;
  logic [G1_EVENTS-1:0] g1_st_nxt;

  assign g2_clr = g2st_lo_we ? data_i[G2_EVENTS-1:0] : '0;
  assign g1_clr = g1st_we ? data_i[G1_EVENTS-1:0] : '0;
  assign g2_any = |(g2_st_r & g2_en_r[G2_EVENTS-1:0]);
  assign op_req = g2_any & g2_en_r[`UIH_G2_MASTER_EN_BIT];
  assign g1_set = g1_event_i | (G1_EVENTS'(op_req) << `UIH_G1_OPREQ_BIT);
  assign g2_st_nxt = (g2_st_r & ~g2_clr) | g2_event_i;
  assign g1_st_nxt = (g1_st_r & ~g1_clr) | g1_set;
  assign g1_any = |(g1_st_r & g1_en_r[G1_EVENTS-1:0]);

  // ****************************************************************
  // Read data select
  // ****************************************************************
  logic [31:0] rd_word;
  logic [15:0] rd_half;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (cmd_r)
      `UIH_CMD_HWCFG_RD: rd_word = {16'h0000, hwcfg_r};
      `UIH_CMD_G2ST_RD: rd_word = 32'(g2_st_r);
      `UIH_CMD_G2EN_RD: rd_word = g2_en_r;
      `UIH_CMD_G1ST_RD: rd_word = 32'(g1_st_r);
      `UIH_CMD_G1EN_RD: rd_word = {16'h0000, g1_en_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign rd_half = phase_r ? rd_word[31:16] : rd_word[15:0];

  // ****************************************************************
  // Command and phase tracking
  // ****************************************************************
  logic full_rst;

  assign full_rst = rst_i | ~reset_n_i;

  always_ff @(posedge clk_i or posedge full_rst) begin
    if (full_rst) begin
      wr_n_q_r <= 1'b1;
      rd_n_q_r <= 1'b1;
      cmd_r <= 8'h00;
      phase_r <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      wr_n_q_r <= wr_n_i | cs_n_i;
      rd_n_q_r <= rd_n_i | cs_n_i;
      data_r <= rd_half;
      if (wr_cmd) begin
        cmd_r <= data_i[7:0];
        phase_r <= 1'b0;
      end else if (wr_data | rd_end) begin
        phase_r <= ~phase_r;
      end
    end
  end

  // ****************************************************************
  // Control and interrupt registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge full_rst) begin
    if (full_rst) begin
      hwcfg_r <= `UIH_HWCFG_RESET;
      g2_st_r <= '0;
      g2_en_r <= `UIH_G2EN_RESET;
      g1_st_r <= '0;
      g1_en_r <= `UIH_G1EN_RESET;
    end else if (soft_rst) begin
      hwcfg_r <= `UIH_HWCFG_RESET;
      g2_st_r <= '0;
      g2_en_r <= `UIH_G2EN_RESET;
      g1_st_r <= '0;
      g1_en_r <= `UIH_G1EN_RESET;
    end else begin
      g2_st_r <= g2_st_nxt;
      g1_st_r <= g1_st_nxt;
      if (hwcfg_we) begin
        hwcfg_r <= data_i;
      end
      if (g2en_lo_we) begin
        g2_en_r[15:0] <= data_i;
      end
      if (g2en_hi_we) begin
        g2_en_r[31:16] <= data_i;
      end
      if (g1en_we) begin
        g1_en_r <= data_i;
      end
    end
  end

  // ****************************************************************
  // Interrupt pin
  // ****************************************************************
  uih_pkg::uih_pin_mode_t pin_mode;

  assign pin_mode = uih_pkg::uih_pin_mode_t'({hwcfg_r[`UIH_HWCFG_TRIG_BIT], hwcfg_r[`UIH_HWCFG_POL_BIT]});

  uih_pin_drive #(
    .PULSE_CYC(PULSE_CYC)
  ) u_pin (
    .clk_i(clk_i),
    .rst_i(full_rst),
    .soft_rst_i(soft_rst),
    .irq_any_i(g1_any),
    .pin_en_i(hwcfg_r[`UIH_HWCFG_PIN_EN_BIT]),
    .mode_i(pin_mode),
    .int_o(int_o)
  );

  assign data_o = data_r;
  assign data_oe_o = rd_data;

endmodule

// >>> uih_irq_top_chk.sv
`timescale 1ns/1ps
`include "uih_consts.svh"
module uih_irq_top_chk #(
  parameter int G2_EVENTS = 6,
  parameter int G1_EVENTS = 6,
  parameter int PULSE_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic a0_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] data_o,
  input wire logic data_oe_o,
  input wire logic [G2_EVENTS-1:0] g2_event_i,
  input wire logic [G1_EVENTS-1:0] g1_event_i,
  input wire logic int_o
);
  // ****
  // Shadow of the pin configuration
  // ****
  logic wp_r, rp_r, ph_r, any_wr_r;
  logic [7:0] cmd_r;
  logic [15:0] cfg_r;
  logic [4:0] stab_r, run_r;
  wire logic ar = rst_i | ~reset_n_i;
  wire logic wt = !cs_n_i && !wr_n_i && wp_r;
  wire logic cw = wt && a0_i && data_i[15:8] == 8'h00;
  wire logic dw = wt && !a0_i;
  wire logic sr = cw && data_i[7:0] == `UIH_CMD_SOFT_RESET;
  wire logic rs = !cs_n_i && !rd_n_i && !a0_i;
  wire logic act = int_o == cfg_r[2];
  wire logic [15:0] cfg_nxt = sr ? 16'h0000 : (dw && !ph_r && cmd_r == `UIH_CMD_HWCFG_WR) ? data_i : cfg_r;
  always_ff @(posedge clk_i or posedge ar) begin
    if (ar) begin
      {wp_r, rp_r, ph_r, any_wr_r, cmd_r, cfg_r, stab_r, run_r} <= {1'b1, 37'h0};
    end else begin
      wp_r <= wr_n_i | cs_n_i;
      rp_r <= rs;
      ph_r <= cw ? 1'b0 : ph_r ^ (dw || (rp_r && rd_n_i && !cs_n_i && !a0_i));
      any_wr_r <= any_wr_r | wt;
      cmd_r <= cw ? data_i[7:0] : cmd_r;
      cfg_r <= cfg_nxt;
      stab_r <= (sr || cfg_nxt != cfg_r) ? 5'h00 : stab_r + {4'h0, ~&stab_r};
      run_r <= act ? run_r + 5'h01 : 5'h00;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (ar);
  property p_oe; data_oe_o == rs; endproperty
  a_oe: assert property (p_oe) else $error("data_oe_o wrong");
  property p_rst; disable iff (1'b0) ar |=> int_o && data_o == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("outputs not reset");
  property p_idle; !any_wr_r |-> int_o; endproperty
  a_idle: assert property (p_idle) else $error("pin moved while disabled");
  property p_hold; stab_r > 5'h02 && !cfg_r[0] && !cfg_r[1] |-> $stable(int_o); endproperty
  a_hold: assert property (p_hold) else $error("pin not held");
  property p_pulse; cfg_r[1] && stab_r > PULSE_CYC + 2 && $fell(act) |-> run_r == PULSE_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too short");
  property p_plen; cfg_r[1] && stab_r > PULSE_CYC + 2 && act |-> run_r < PULSE_CYC; endproperty
  a_plen: assert property (p_plen) else $error("pulse too long");
  property p_soft; sr |-> ##2 int_o ##1 int_o; endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_rd; rs && !rp_r && !ph_r && cmd_r == `UIH_CMD_HWCFG_RD |=> data_o == cfg_r; endproperty
  a_rd: assert property (p_rd) else $error("config read wrong");
  c_soft: cover property (sr);
  c_pulse: cover property (cfg_r[1] && $fell(act));
  c_rd: cover property (rs && !rp_r);
endmodule
bind uih_irq_top uih_irq_top_chk #(.G2_EVENTS(G2_EVENTS), .G1_EVENTS(G1_EVENTS), .PULSE_CYC(PULSE_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .a0_i(a0_i), .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .g2_event_i(g2_event_i),
  .g1_event_i(g1_event_i), .int_o(int_o));

// >>> uih_cpu_model.sv
`timescale 1ns/1ps
`include "uih_consts.svh"
module uih_cpu_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic cs_n_o = 1'b1,
  output logic a0_o = 1'b0,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic [15:0] wdata_o = 16'h0000
);
  // ****
  // Bus cycles
  // ****
  task automatic wr(input logic a, input logic [15:0] d);
    @(posedge clk_i);
    a0_o <= a;
    wdata_o <= d;
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    wdata_o <= ~d;
  endtask
  task automatic set(input logic [7:0] c, input logic [15:0] v);
    wr(1'b1, {8'h00, c});
    wr(1'b0, v);
  endtask
  task automatic set32(input logic [7:0] c, input logic [31:0] v);
    set(c, v[15:0]);
    wr(1'b0, v[31:16]);
  endtask
  // Select held one edge past the strobe so the read phase is counted
  task automatic rd(output logic [15:0] d);
    @(posedge clk_i);
    a0_o <= 1'b0;
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    d = rdata_i;
    rd_n_o <= 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
  endtask
  task automatic get(input logic [7:0] c, output logic [15:0] d);
    wr(1'b1, {8'h00, c});
    rd(d);
  endtask
  task automatic get32(input logic [7:0] c, output logic [31:0] d);
    logic [15:0] lo;
    logic [15:0] hi;
    wr(1'b1, {8'h00, c});
    rd(lo);
    rd(hi);
    d = {hi, lo};
  endtask
  // ****
  // Pin disable and restore
  // ****
  task automatic pin_off(input logic mask);
    logic [15:0] d;
    get(`UIH_CMD_HWCFG_RD, d);
    if (d[0]) begin
      if (mask)
        set(`UIH_CMD_G1EN_WR, 16'h0000);
      else
        set(`UIH_CMD_G1ST_WR, 16'hFFFF);
      set(`UIH_CMD_HWCFG_WR, d & 16'hFFFE);
    end
  endtask
  task automatic pin_on(input logic mask, input logic [15:0] en);
    logic [15:0] d;
    if (mask)
      set(`UIH_CMD_G1EN_WR, en);
    else
      set(`UIH_CMD_G1ST_WR, 16'hFFFF);
    get(`UIH_CMD_HWCFG_RD, d);
    set(`UIH_CMD_HWCFG_WR, d | 16'h0001);
  endtask
endmodule

// >>> test_usb_host_irq_aggregator.sv
`timescale 1ns/1ps
`include "uih_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_usb_host_irq_aggregator;
  typedef struct packed {logic [15:0] cfg; logic idle; logic act; logic after;} uih_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic cs_n, a0, rd_n, wr_n, data_oe, int_o;
  logic [15:0] wdata, rdata, d;
  logic [31:0] d32;
  logic [5:0] g2_ev = 6'h00;
  logic [5:0] g1_ev = 6'h00;
  int mismatches = 0;
  int checked = 0;
  uih_row_t rows [4] = '{'{16'h0001, 1'b1, 1'b0, 1'b0}, '{16'h0005, 1'b0, 1'b1, 1'b1},
    '{16'h0003, 1'b1, 1'b0, 1'b1}, '{16'h0007, 1'b0, 1'b1, 1'b0}};
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  uih_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .cs_n_o(cs_n), .a0_o(a0), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .wdata_o(wdata));
  uih_irq_top #(.PULSE_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .a0_i(a0),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe), .g2_event_i(g2_ev),
    .g1_event_i(g1_ev), .int_o(int_o));
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic ev(input logic [5:0] a, input logic [5:0] b);
    @(posedge clk_i);
    g2_ev <= a;
    g1_ev <= b;
    @(posedge clk_i);
    g2_ev <= 6'h00;
    g1_ev <= 6'h00;
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****
  // Watchdog: tests need about 330 cycles
  // ****
  initial begin
    #60000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    `CHK("int_o rst", 1'b1, int_o)
    rst_i <= 1'b0;
    ev(6'h3F, 6'h3F);
    w(4);
    `CHK("int_o off", 1'b1, int_o)
    cpu.get(`UIH_CMD_HWCFG_RD, d);
    `CHK("hwcfg rst", 16'h0000, d)
    cpu.set(`UIH_CMD_G2ST_WR, 16'h003F);
    cpu.set(`UIH_CMD_G1ST_WR, 16'h003F);
    cpu.set(`UIH_CMD_G1EN_WR, 16'h0001);
    foreach (rows[i]) begin
      cpu.set(`UIH_CMD_HWCFG_WR, rows[i].cfg);
      cpu.get(`UIH_CMD_HWCFG_RD, d);
      `CHK("hwcfg", rows[i].cfg, d)
      `CHK("int_o idle", rows[i].idle, int_o)
      ev(6'h00, 6'h01);
      w(3);
      `CHK("int_o act", rows[i].act, int_o)
      w(8);
      `CHK("int_o end", rows[i].after, int_o)
      cpu.set(`UIH_CMD_G1ST_WR, 16'h0001);
      w(3);
      `CHK("int_o clr", rows[i].idle, int_o)
    end
    cpu.set(`UIH_CMD_HWCFG_WR, 16'h0005);
    cpu.set(`UIH_CMD_G1EN_WR, 16'h0011);
    cpu.set32(`UIH_CMD_G2EN_WR, 32'h0000_0001);
    ev(6'h01, 6'h00);
    w(4);
    `CHK("int_o gated", 1'b0, int_o)
    cpu.get(`UIH_CMD_G2ST_RD, d);
    `CHK("g2 status", 16'h0001, d)
    cpu.set32(`UIH_CMD_G2EN_WR, 32'h8000_0001);
    w(4);
    `CHK("int_o g2", 1'b1, int_o)
    cpu.get32(`UIH_CMD_G2EN_RD, d32);
    `CHK("g2 enable", 32'h8000_0001, d32)
    cpu.get(`UIH_CMD_G1ST_RD, d);
    `CHK("opreq", 16'h0010, d)
    cpu.set(`UIH_CMD_G2ST_WR, 16'h0001);
    cpu.pin_off(1'b1);
    w(3);
    `CHK("int_o mask", 1'b0, int_o)
    cpu.get(`UIH_CMD_G1ST_RD, d);
    `CHK("kept", 16'h0010, d)
    cpu.set(`UIH_CMD_G1EN_WR, 16'h0011);
    ev(6'h00, 6'h01);
    w(4);
    `CHK("int_o held", 1'b0, int_o)
    cpu.pin_on(1'b1, 16'h0011);
    w(3);
    `CHK("int_o unmask", 1'b1, int_o)
    cpu.pin_off(1'b0);
    w(3);
    `CHK("int_o dis", 1'b0, int_o)
    cpu.pin_on(1'b0, 16'h0011);
    w(3);
    `CHK("int_o ena", 1'b0, int_o)
    ev(6'h00, 6'h01);
    w(3);
    `CHK("int_o new", 1'b1, int_o)
    cpu.wr(1'b1, {8'h00, `UIH_CMD_SOFT_RESET});
    w(2);
    cpu.get(`UIH_CMD_G1ST_RD, d);
    `CHK("soft st", 16'h0000, d)
    cpu.get(`UIH_CMD_HWCFG_RD, d);
    `CHK("soft cfg", 16'h0000, d)
    cpu.set(`UIH_CMD_HWCFG_WR, 16'h0005);
    cpu.get(`UIH_CMD_HWCFG_RD, d);
    `CHK("hwcfg set", 16'h0005, d)
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    cpu.get(`UIH_CMD_HWCFG_RD, d);
    `CHK("pin rst", 16'h0000, d)
    `CHK("int_o pin rst", 1'b1, int_o)
    finish_test();
  end
endmodule
